// file: common/etss_consts.svh
`ifndef ETSS_CONSTS_SVH
`define ETSS_CONSTS_SVH

// Register byte offsets
`define ETSS_ADDR_CTRL      8'h00
`define ETSS_ADDR_STATUS    8'h04
`define ETSS_ADDR_IRQ_STS   8'h08
`define ETSS_ADDR_IRQ_CLR   8'h0c
`define ETSS_ADDR_IRQ_EN    8'h10

// Control field positions
`define ETSS_CTRL_SEL_A_LSB 0
`define ETSS_CTRL_B_SRC_LSB 4
`define ETSS_CTRL_B_IDX_LSB 6
`define ETSS_CTRL_SEL_C_BIT 10
`define ETSS_CTRL_SQL_BIT   11
`define ETSS_CTRL_EXT_BIT   12
`define ETSS_CTRL_RESET     32'h0000_0000

// Status field positions
`define ETSS_STS_MODE_LSB   0
`define ETSS_STS_LOST_BIT   2
`define ETSS_STS_LOS_BIT    3
`define ETSS_STS_SELV_BIT   4
`define ETSS_STS_VALID_LSB  16

// Interrupt bits
`define ETSS_IRQ_LOST_BIT   0
`define ETSS_IRQ_LOS_BIT    1
`define ETSS_IRQ_MODE_BIT   2
`define ETSS_IRQ_RESET      3'h0

// Timing
`define ETSS_CLK_PERIOD_PS  5000
`define ETSS_LOS_TIME_NS    1000
`define ETSS_FREE_PERIOD_NS 125

`endif

// file: common/etss_pkg.sv
`default_nettype none
package etss_pkg;
	typedef enum logic [1:0] {
		etss_free_run,
		etss_locked,
		etss_holdover
	} etss_mode_t;

	typedef enum logic [1:0] {
		etss_src_line,
		etss_src_trib,
		etss_src_ext
	} etss_src_t;
endpackage : etss_pkg
`default_nettype wire

// file: src/etss_sync_port.sv
`include "etss_consts.svh"
`default_nettype none
module etss_sync_port #(
	parameter int PER_W   = 12,
	parameter int LOS_CYC = 200
) (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic sync_port_rx,
	input  wire logic tx_timing,
	input  wire logic tx_path_en,
	input  wire logic squelch,
	output var  logic sync_port_tx,
	output var  logic ext_ref_edge,
	output var  logic ext_ref_valid,
	output var  logic loss_of_signal_cause
);
	import etss_pkg::*;

	logic             rx_s1_q;
	logic             rx_s2_q;
	logic             rx_prev_q;
	logic [PER_W-1:0] act_cnt_q;
	logic             tx_q;
	logic             los_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_s1_q   <= 1'b0;
			rx_s2_q   <= 1'b0;
			rx_prev_q <= 1'b0;
		end else begin
			rx_s1_q   <= sync_port_rx;
			rx_s2_q   <= rx_s1_q;
			rx_prev_q <= rx_s2_q;
		end
	end

	// Recovered timing: one pulse per rising edge of the port signal
	assign ext_ref_edge  = rx_s2_q & ~rx_prev_q;
	assign ext_ref_valid = act_cnt_q < PER_W'(LOS_CYC);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			act_cnt_q <= PER_W'(LOS_CYC);
		end else if (ext_ref_edge) begin
			act_cnt_q <= '0;
		end else if (act_cnt_q < PER_W'(LOS_CYC)) begin
			act_cnt_q <= act_cnt_q + 1'b1;
		end
	end

	// Cause follows the defect directly
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			los_q <= 1'b1;
		end else begin
			los_q <= ~ext_ref_valid;
		end
	end

	// Transmit timing passes unchanged, or idles low when off
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_q <= 1'b0;
		end else begin
			tx_q <= tx_path_en & ~squelch & tx_timing;
		end
	end

	assign sync_port_tx         = tx_q;
	assign loss_of_signal_cause = los_q;

	a_squelch_idle: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		squelch |=> !sync_port_tx
	) else $error("sync output active while squelched");

	a_path_absent: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!tx_path_en |=> !sync_port_tx
	) else $error("sync output active with path disabled");

	a_tx_transparent: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(tx_path_en && !squelch) |=> (sync_port_tx == $past(tx_timing))
	) else $error("sync output differs from its timing");

	a_los_report: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(act_cnt_q >= PER_W'(LOS_CYC)) |=> loss_of_signal_cause
	) else $error("loss of signal not reported");
endmodule : etss_sync_port
`default_nettype wire

// file: src/etss_timing_source.sv
// Function
// - Equipment clock distributed to internal functional blocks
// - Reference chosen from line, tributary or external
// - Report all references lost to management
// - First selector picks one line reference
// - Second selector picks one reference for generator
// - Generator runs locked, holdover or free run
// - Sync output from equipment clock or line
// - Squelch provisioning disables sync_port_tx; external_sync_out keeps running
// - Sync port loss of signal reported
// - Outgoing sync path only when enabled
// - Transmit sync follows output timing unchanged
// - Received sync timing feeds external reference
//
// The implementer's own choices: the address-and-strobe port and the address map.
`include "etss_consts.svh"
`default_nettype none
module etss_timing_source #(
	parameter int N_LINE = 4,
	parameter int N_TRIB = 4,
	parameter int PER_W  = 12
) (
	input  wire logic          clk_sys,
	input  wire logic          resetn,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output var  logic [31:0]   reg_rdata,
	input  wire logic [N_LINE-1:0] line_derived_ref,
	input  wire logic [N_TRIB-1:0] tributary_derived_ref,
	input  wire logic          sync_port_rx,
	output var  logic          sync_port_tx,
	output var  logic          equipment_clock_point,
	output var  logic          external_sync_out,
	output var  logic          all_refs_lost,
	output var  logic          loss_of_signal_cause,
	output var  etss_pkg::etss_mode_t timing_mode,
	output var  logic          irq
);
	import etss_pkg::*;

	localparam int NREF = N_LINE + N_TRIB;
	localparam int LOS_CYC = (`ETSS_LOS_TIME_NS * 1000 +
		`ETSS_CLK_PERIOD_PS - 1) / `ETSS_CLK_PERIOD_PS;
	localparam int FREE_CYC = (`ETSS_FREE_PERIOD_NS * 1000) /
		`ETSS_CLK_PERIOD_PS;

	function automatic logic etss_pick(input logic [15:0] v,
		input logic [3:0] i);
		return v[i];
	endfunction : etss_pick

	logic [NREF-1:0]  ref_s1_q;
	logic [NREF-1:0]  ref_s2_q;
	logic [NREF-1:0]  ref_prev_q;
	logic [NREF-1:0]  ref_edge;
	logic [NREF-1:0]  ref_valid;
	logic [PER_W-1:0] act_cnt_q [NREF];
	logic [15:0]      line_edge;
	logic [15:0]      line_valid;
	logic [15:0]      line_level;
	logic [15:0]      trib_edge;
	logic [15:0]      trib_valid;

	logic [3:0]       sel_a_q;
	etss_src_t        b_src_q;
	logic [3:0]       b_idx_q;
	logic             sel_c_q;
	logic             squelch_q;
	logic             ext_en_q;

	logic             ext_edge;
	logic             ext_valid;
	logic             ext_los;
	logic             a_level;
	logic             sel_edge;
	logic             sel_valid;
	logic             any_valid;
	logic             ctrl_wr;

	logic [PER_W-1:0] per_cnt_q;
	logic [PER_W-1:0] meas_q;
	logic [PER_W-1:0] hold_per_q;
	logic             seen_q;
	logic             meas_ok_q;
	logic [PER_W-1:0] cur_per;
	logic [PER_W-1:0] phase_q;
	etss_mode_t       mode_q;
	etss_mode_t       mode_d;

	logic             eq_clk_q;
	logic             ext_out_q;
	logic             lost_q;
	logic             los_prev_q;
	logic [2:0]       irq_sts_q;
	logic [2:0]       irq_en_q;
	logic [2:0]       irq_ev;
	logic             irq_q;
	logic [31:0]      rdata_q;

	// Pin synchronisers for all line and tributary references
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ref_s1_q   <= '0;
			ref_s2_q   <= '0;
			ref_prev_q <= '0;
		end else begin
			ref_s1_q   <= {tributary_derived_ref, line_derived_ref};
			ref_s2_q   <= ref_s1_q;
			ref_prev_q <= ref_s2_q;
		end
	end

	assign ref_edge = ref_s2_q & ~ref_prev_q;

	// Activity monitor: a reference is valid while edges keep coming
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NREF; i++) begin
				act_cnt_q[i] <= PER_W'(LOS_CYC);
			end
		end else begin
			for (int i = 0; i < NREF; i++) begin
				if (ref_edge[i]) begin
					act_cnt_q[i] <= '0;
				end else if (act_cnt_q[i] < PER_W'(LOS_CYC)) begin
					act_cnt_q[i] <= act_cnt_q[i] + 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NREF; i++) begin
			ref_valid[i] = act_cnt_q[i] < PER_W'(LOS_CYC);
		end
	end

	assign line_edge  = 16'(ref_edge[N_LINE-1:0]);
	assign line_valid = 16'(ref_valid[N_LINE-1:0]);
	assign line_level = 16'(ref_s2_q[N_LINE-1:0]);
	assign trib_edge  = 16'(ref_edge[NREF-1:N_LINE]);
	assign trib_valid = 16'(ref_valid[NREF-1:N_LINE]);

	etss_sync_port #(
		.PER_W   (PER_W),
		.LOS_CYC (LOS_CYC)
	) u_sync_port (
		.clk_sys              (clk_sys),
		.resetn               (resetn),
		.sync_port_rx         (sync_port_rx),
		.tx_timing            (ext_out_q),
		.tx_path_en           (ext_en_q),
		.squelch              (squelch_q),
		.sync_port_tx         (sync_port_tx),
		.ext_ref_edge         (ext_edge),
		.ext_ref_valid        (ext_valid),
		.loss_of_signal_cause (ext_los)
	);

	// First selector: one line reference
	assign a_level = etss_pick(line_level, sel_a_q);

	// Second selector: one reference of any kind for the generator
	always_comb begin
		case (b_src_q)
			etss_src_line: begin
				sel_edge  = etss_pick(line_edge, b_idx_q);
				sel_valid = etss_pick(line_valid, b_idx_q);
			end
			etss_src_trib: begin
				sel_edge  = etss_pick(trib_edge, b_idx_q);
				sel_valid = etss_pick(trib_valid, b_idx_q);
			end
			etss_src_ext: begin
				sel_edge  = ext_edge;
				sel_valid = ext_valid;
			end
			default: begin
				sel_edge  = 1'b0;
				sel_valid = 1'b0;
			end
		endcase
	end

	assign any_valid = (|ref_valid) | ext_valid;
	assign ctrl_wr   = reg_wr && (reg_addr == `ETSS_ADDR_CTRL);

	// Control register: selectors change only on a software write
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sel_a_q   <= 4'h0;
			b_src_q   <= etss_src_line;
			b_idx_q   <= 4'h0;
			sel_c_q   <= 1'b0;
			squelch_q <= 1'b0;
			ext_en_q  <= 1'b0;
		end else if (ctrl_wr) begin
			sel_a_q   <= reg_wdata[`ETSS_CTRL_SEL_A_LSB +: 4];
			b_src_q   <= etss_src_t'(reg_wdata[`ETSS_CTRL_B_SRC_LSB +: 2]);
			b_idx_q   <= reg_wdata[`ETSS_CTRL_B_IDX_LSB +: 4];
			sel_c_q   <= reg_wdata[`ETSS_CTRL_SEL_C_BIT];
			squelch_q <= reg_wdata[`ETSS_CTRL_SQL_BIT];
			ext_en_q  <= reg_wdata[`ETSS_CTRL_EXT_BIT];
		end
	end

	// Period of the selected reference, restarted on reselection
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			per_cnt_q <= '0;
			meas_q    <= PER_W'(FREE_CYC);
			seen_q    <= 1'b0;
			meas_ok_q <= 1'b0;
		end else if (ctrl_wr) begin
			per_cnt_q <= '0;
			seen_q    <= 1'b0;
			meas_ok_q <= 1'b0;
		end else if (sel_edge) begin
			per_cnt_q <= '0;
			seen_q    <= 1'b1;
			if (seen_q) begin
				meas_q    <= per_cnt_q + 1'b1;
				meas_ok_q <= 1'b1;
			end
		end else if (per_cnt_q != '1) begin
			per_cnt_q <= per_cnt_q + 1'b1;
		end
	end

	// Generator mode selection
	always_comb begin
		case (mode_q)
			etss_free_run: begin
				mode_d = (sel_valid && meas_ok_q) ? etss_locked
					: etss_free_run;
			end
			etss_locked: begin
				mode_d = sel_valid ? etss_locked : etss_holdover;
			end
			etss_holdover: begin
				mode_d = (sel_valid && meas_ok_q) ? etss_locked
					: etss_holdover;
			end
			default: begin
				mode_d = etss_free_run;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_q <= etss_free_run;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Period remembered for holdover
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hold_per_q <= PER_W'(FREE_CYC);
		end else if (mode_q == etss_locked) begin
			hold_per_q <= meas_q;
		end
	end

	always_comb begin
		case (mode_q)
			etss_locked:   cur_per = meas_q;
			etss_holdover: cur_per = hold_per_q;
			default:       cur_per = PER_W'(FREE_CYC);
		endcase
	end

	// Phase accumulator, aligned to the reference while locked
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_q <= '0;
		end else if (mode_q == etss_locked && sel_edge) begin
			phase_q <= '0;
		end else if (phase_q >= cur_per - 1'b1) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			eq_clk_q <= 1'b0;
		end else begin
			eq_clk_q <= phase_q < (cur_per >> 1);
		end
	end

	// Third selector
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_out_q <= 1'b0;
		end else begin
			ext_out_q <= sel_c_q ? a_level : eq_clk_q;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lost_q     <= 1'b1;
			los_prev_q <= 1'b1;
		end else begin
			lost_q     <= ~any_valid;
			los_prev_q <= ext_los;
		end
	end

	// Interrupt events: a new set beats a clear in the same cycle
	assign irq_ev[`ETSS_IRQ_LOST_BIT] = ~any_valid & ~lost_q;
	assign irq_ev[`ETSS_IRQ_LOS_BIT]  = ext_los & ~los_prev_q;
	assign irq_ev[`ETSS_IRQ_MODE_BIT] = mode_d != mode_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_sts_q <= `ETSS_IRQ_RESET;
		end else if (reg_wr && reg_addr == `ETSS_ADDR_IRQ_CLR) begin
			irq_sts_q <= (irq_sts_q & ~reg_wdata[2:0]) | irq_ev;
		end else begin
			irq_sts_q <= irq_sts_q | irq_ev;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_en_q <= `ETSS_IRQ_RESET;
		end else if (reg_wr && reg_addr == `ETSS_ADDR_IRQ_EN) begin
			irq_en_q <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_sts_q & irq_en_q);
		end
	end

	// Read port: data valid the cycle after the strobe only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 32'h0;
		end else if (!reg_rd) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= 32'h0;
			case (reg_addr)
				`ETSS_ADDR_CTRL: begin
					rdata_q[`ETSS_CTRL_SEL_A_LSB +: 4] <= sel_a_q;
					rdata_q[`ETSS_CTRL_B_SRC_LSB +: 2] <= b_src_q;
					rdata_q[`ETSS_CTRL_B_IDX_LSB +: 4] <= b_idx_q;
					rdata_q[`ETSS_CTRL_SEL_C_BIT] <= sel_c_q;
					rdata_q[`ETSS_CTRL_SQL_BIT]   <= squelch_q;
					rdata_q[`ETSS_CTRL_EXT_BIT]   <= ext_en_q;
				end
				`ETSS_ADDR_STATUS: begin
					rdata_q[`ETSS_STS_MODE_LSB +: 2] <= mode_q;
					rdata_q[`ETSS_STS_LOST_BIT] <= lost_q;
					rdata_q[`ETSS_STS_LOS_BIT]  <= ext_los;
					rdata_q[`ETSS_STS_SELV_BIT] <= sel_valid;
					rdata_q[`ETSS_STS_VALID_LSB +: 16] <= 16'(ref_valid);
				end
				`ETSS_ADDR_IRQ_STS: rdata_q[2:0] <= irq_sts_q;
				`ETSS_ADDR_IRQ_EN:  rdata_q[2:0] <= irq_en_q;
				default:            rdata_q <= 32'h0;
			endcase
		end
	end

	assign reg_rdata             = rdata_q;
	assign equipment_clock_point = eq_clk_q;
	assign external_sync_out     = ext_out_q;
	assign all_refs_lost         = lost_q;
	assign loss_of_signal_cause  = ext_los;
	assign timing_mode           = mode_q;
	assign irq                   = irq_q;

	a_all_lost: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!any_valid |=> all_refs_lost
	) else $error("loss of all references not reported");

	a_enter_hold: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(mode_q == etss_locked && !sel_valid) |=> mode_q == etss_holdover
	) else $error("no holdover after reference loss");

	a_stay_free: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(mode_q == etss_free_run && !sel_valid) |=> mode_q == etss_free_run
	) else $error("left free run without a reference");

	a_lock_phase: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(mode_q == etss_locked && sel_edge) |=> phase_q == '0
	) else $error("locked phase not aligned to reference");

	a_selc_stable: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		!ctrl_wr |=> $stable(sel_c_q)
	) else $error("third selector moved without command");

	a_out_select: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		sel_c_q |=> external_sync_out == $past(a_level)
	) else $error("sync output not from line reference");

	a_lock_needs_ref: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(mode_q != etss_locked && !(sel_valid && meas_ok_q))
			|=> mode_q != etss_locked
	) else $error("locked without a measured reference");

	a_squelch_out: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		squelch_q ##1 squelch_q |=> !sync_port_tx
	) else $error("squelch did not disable sync output");
endmodule : etss_timing_source
`default_nettype wire

// file: verification/etss_ref_model.sv
`default_nettype none
module etss_ref_model (
	input  wire logic [3:0] line_en,
	input  wire logic [3:0] trib_en,
	input  wire logic       rx_en,
	output var  logic [3:0] line_ref,
	output var  logic [3:0] trib_ref,
	output var  logic       rx_sync
);
	timeunit 1ns;
	timeprecision 100ps;

	// Line and tributary clocks, each its own period, stand low when lost
	for (genvar i = 0; i < 4; i++) begin : g_ref
		initial begin
			line_ref[i] = 1'b0;
			forever begin
				#(40 + 10 * i);
				line_ref[i] = line_en[i] ? ~line_ref[i] : 1'b0;
			end
		end
		initial begin
			trib_ref[i] = 1'b0;
			forever begin
				#(75 + 5 * i);
				trib_ref[i] = trib_en[i] ? ~trib_ref[i] : 1'b0;
			end
		end
	end

	// External sync clock, 125 ns, phase unrelated to the system clock
	initial begin
		rx_sync = 1'b0;
		#3.3;
		forever begin
			#62.5;
			rx_sync = rx_en ? ~rx_sync : 1'b0;
		end
	end
endmodule : etss_ref_model
`default_nettype wire

// file: verification/tb.sv
`include "etss_consts.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import etss_pkg::*;

	logic        clk_sys;
	logic        resetn;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [3:0]  line_en;
	logic [3:0]  trib_en;
	logic        rx_en;
	logic [3:0]  line_ref;
	logic [3:0]  trib_ref;
	logic        rx_sync;
	logic        sync_port_tx;
	logic        equipment_clock_point;
	logic        external_sync_out;
	logic        all_refs_lost;
	logic        loss_of_signal_cause;
	etss_mode_t  timing_mode;
	logic        irq;
	logic        rd_seen;
	logic [31:0] seed;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          error_cnt;
	int          compares;

	etss_timing_source dut (
		.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .line_derived_ref(line_ref),
		.tributary_derived_ref(trib_ref), .sync_port_rx(rx_sync),
		.sync_port_tx(sync_port_tx),
		.equipment_clock_point(equipment_clock_point),
		.external_sync_out(external_sync_out),
		.all_refs_lost(all_refs_lost),
		.loss_of_signal_cause(loss_of_signal_cause),
		.timing_mode(timing_mode), .irq(irq)
	);

	etss_ref_model u_refs (
		.line_en(line_en), .trib_en(trib_en), .rx_en(rx_en),
		.line_ref(line_ref), .trib_ref(trib_ref), .rx_sync(rx_sync)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic report_and_stop;
		$display("Compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask : rd

	// Read data stand only in the cycle after the strobe
	always @(posedge clk_sys) begin
		rd_seen <= reg_rd;
		if (rd_seen === 1'b1) begin
			check(reg_rdata & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	task automatic wait_mode(input etss_mode_t m);
		int n;
		n = 0;
		while (timing_mode !== m && n < 800) begin
			@(negedge clk_sys);
			n++;
		end
		check({30'h0, timing_mode}, {30'h0, m});
		if (timing_mode !== m) report_and_stop();
	endtask : wait_mode

	task automatic count_rise(input int sel, input int n, input int e);
		logic p;
		logic v;
		int c;
		c = 0;
		p = 1'b1;
		repeat (n) begin
			@(negedge clk_sys);
			v = sel == 0 ? external_sync_out :
				sel == 1 ? equipment_clock_point : sync_port_tx;
			if (v === 1'b1 && p === 1'b0) c++;
			p = v;
		end
		check({31'h0, (e == 0) ? (c == 0) : (c >= e - 1 && c <= e + 1)},
			32'h1);
	endtask : count_rise

	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		$display("Error at %0t: run limit reached", $time);
		report_and_stop();
	end

	initial begin
		logic eq_p;
		logic out_p;
		int   k;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		line_en = 4'h0;
		trib_en = 4'h0;
		rx_en = 1'b0;
		seed = 32'hda2a;
		error_cnt = 0;
		compares = 0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		// Reset values, refused accesses
		rd(`ETSS_ADDR_CTRL, 32'h0, 32'hffffffff);
		rd(`ETSS_ADDR_STATUS, 32'h0c, 32'hffff001f);
		rd(`ETSS_ADDR_IRQ_STS, 32'h0, 32'hffffffff);
		rd(`ETSS_ADDR_IRQ_CLR, 32'h0, 32'hffffffff);
		seed = xs(seed);
		wr(8'h20, seed);
		rd(8'h20, 32'h0, 32'hffffffff);
		rd(`ETSS_ADDR_CTRL, 32'h0, 32'hffffffff);
		count_rise(1, 500, 20);
		wr(`ETSS_ADDR_IRQ_EN, 32'h7);
		line_en <= 4'hf;
		trib_en <= 4'hf;
		rx_en <= 1'b1;
		repeat (100) @(negedge clk_sys);
		check({30'h0, all_refs_lost, loss_of_signal_cause}, 32'h0);
		rd(`ETSS_ADDR_STATUS, 32'h00ff0000, 32'hffff000c);
		// Every source kind of the second selector
		for (int s = 0; s < 3; s++) begin
			seed = xs(seed);
			wr(`ETSS_ADDR_CTRL, (s << 4) | (seed[1:0] << 6));
			wait_mode(etss_locked);
			rd(`ETSS_ADDR_STATUS, 32'h11, 32'h1f);
		end
		seed = xs(seed);
		k = seed[1:0];
		wr(`ETSS_ADDR_CTRL, k << 6);
		wait_mode(etss_locked);
		line_en[k] <= 1'b0;
		wait_mode(etss_holdover);
		line_en[k] <= 1'b1;
		wait_mode(etss_locked);
		// Output from equipment clock, passed on unchanged
		wr(`ETSS_ADDR_CTRL, 32'h1000);
		repeat (4) @(negedge clk_sys);
		eq_p = equipment_clock_point;
		out_p = external_sync_out;
		repeat (100) begin
			@(negedge clk_sys);
			check({31'h0, external_sync_out}, {31'h0, eq_p});
			check({31'h0, sync_port_tx}, {31'h0, out_p});
			eq_p = equipment_clock_point;
			out_p = external_sync_out;
		end
		// Output from each line reference through the first selector
		for (int j = 0; j < 4; j++) begin
			wr(`ETSS_ADDR_CTRL, 32'h1400 | j);
			repeat (10) @(negedge clk_sys);
			count_rise(0, 560, 2800 / (80 + 20 * j));
		end
		wr(`ETSS_ADDR_CTRL, 32'h1c00);
		count_rise(2, 200, 0);
		wr(`ETSS_ADDR_CTRL, 32'h0400);
		count_rise(2, 200, 0);
		// Interrupt set, masked and cleared
		wr(`ETSS_ADDR_IRQ_CLR, 32'h7);
		repeat (3) @(negedge clk_sys);
		check({31'h0, irq}, 32'h0);
		wr(`ETSS_ADDR_IRQ_EN, 32'h2);
		rx_en <= 1'b0;
		repeat (300) @(negedge clk_sys);
		check({31'h0, loss_of_signal_cause}, 32'h1);
		check({31'h0, irq}, 32'h1);
		rd(`ETSS_ADDR_IRQ_STS, 32'h2, 32'h2);
		wr(`ETSS_ADDR_IRQ_EN, 32'h0);
		repeat (3) @(negedge clk_sys);
		check({31'h0, irq}, 32'h0);
		wr(`ETSS_ADDR_IRQ_EN, 32'h2);
		wr(`ETSS_ADDR_IRQ_CLR, 32'h2);
		repeat (3) @(negedge clk_sys);
		check({31'h0, irq}, 32'h0);
		// Every reference lost while locked
		line_en <= 4'h0;
		trib_en <= 4'h0;
		repeat (300) @(negedge clk_sys);
		check({31'h0, all_refs_lost}, 32'h1);
		rd(`ETSS_ADDR_STATUS, 32'h6, 32'h7);
		rd(`ETSS_ADDR_IRQ_STS, 32'h1, 32'h1);
		repeat (3) @(posedge clk_sys);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
